// ---- iedr_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef IEDR_MAP_SVH
`define IEDR_MAP_SVH

// Register offsets on the control port
`define IEDR_OFS_ALARM_PEND   8'h13
`define IEDR_OFS_MISC_PEND    8'h14
`define IEDR_OFS_ALARM_MASK   8'h16
`define IEDR_OFS_MISC_MASK    8'h17
`define IEDR_OFS_DIGIT_STAT   8'h18
`define IEDR_OFS_IDATA_LO     8'h1C
`define IEDR_OFS_IDATA_HI     8'h1D
`define IEDR_OFS_IADDR        8'h1E
`define IEDR_OFS_ISTAT        8'h1F

// Field positions
`define IEDR_ALARM_HI_BIT     7
`define IEDR_ALARM_LO_BIT     2
`define IEDR_LOOP_BIT         1
`define IEDR_RTRIP_BIT        0
`define IEDR_CMCAL_BIT        2
`define IEDR_INDDONE_BIT      1
`define IEDR_TONE_BIT         0
`define IEDR_DIGIT_VALID_BIT  4
`define IEDR_ISTAT_PEND_BIT   0

// Reset values
`define IEDR_RST_BYTE         8'h00
`define IEDR_RST_WORD         16'h0000
`define IEDR_RST_MISC         3'h0

// Timing: indirect update tick
`define IEDR_CLK_HZ           250000000
`define IEDR_TICK_HZ          16000
`define IEDR_TICK_CYCLES      (`IEDR_CLK_HZ / `IEDR_TICK_HZ)

`endif

// ---- iedr_pkg.sv ----
// Types shared by the interrupt mask, tone status and indirect access logic
package iedr_pkg;

  typedef enum logic [0:0] {
    IEDR_OP_READ  = 1'b0,
    IEDR_OP_WRITE = 1'b1
  } iedr_op_e;

  typedef enum logic [3:0] {
    IEDR_DIG_D     = 4'h0,
    IEDR_DIG_1     = 4'h1,
    IEDR_DIG_2     = 4'h2,
    IEDR_DIG_3     = 4'h3,
    IEDR_DIG_4     = 4'h4,
    IEDR_DIG_5     = 4'h5,
    IEDR_DIG_6     = 4'h6,
    IEDR_DIG_7     = 4'h7,
    IEDR_DIG_8     = 4'h8,
    IEDR_DIG_9     = 4'h9,
    IEDR_DIG_0     = 4'hA,
    IEDR_DIG_STAR  = 4'hB,
    IEDR_DIG_POUND = 4'hC,
    IEDR_DIG_A     = 4'hD,
    IEDR_DIG_B     = 4'hE,
    IEDR_DIG_C     = 4'hF
  } iedr_digit_e;

  // Event group feeding the alarm pending flags
  typedef struct packed {
    logic [5:0] alarm;
    logic       loop_closure;
    logic       ring_trip;
  } iedr_evt_s;

  typedef struct packed {
    logic [7:0]  alarm_mask;
    logic [2:0]  misc_mask;
    logic [7:0]  alarm_pend;
    logic [2:0]  misc_pend;
    logic        digit_valid;
    iedr_digit_e digit_code;
    logic        valid_prev;
    logic [15:0] idata;
    logic [7:0]  iaddr;
    logic        ipend;
    iedr_op_e    iop;
    logic        data_dirty;
    logic [2:0]  hook_sync;
    logic        hook_prev;
    logic        hook_seen;
    logic [7:0]  rdata;
    logic        irq_n;
  } iedr_state_s;

  typedef struct packed {
    logic [13:0] count;
    logic        tick;
  } iedr_tick_s;

  typedef struct packed {
    logic [255:0][15:0] cells;
  } iedr_mem_s;

endpackage

// ---- iedr_tick.sv ----
// Free-running divider producing the indirect update tick
`timescale 1ns/10ps
`include "iedr_map.svh"
module iedr_tick #(
  parameter int TICK_CYCLES = `IEDR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Tick out, one cycle wide
  output logic      tick
);

  iedr_pkg::iedr_tick_s s_r;
  iedr_pkg::iedr_tick_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.count == 14'h0000) begin
      s_nxt.count = 14'(TICK_CYCLES - 1);
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.count = s_r.count - 14'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule // iedr_tick

// ---- iedr_mem.sv ----
// Indirect register store, 256 words of 16 bits in flip-flops
`timescale 1ns/10ps
module iedr_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Access port
  input  wire logic        we,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata
);

  iedr_pkg::iedr_mem_s s_r;
  iedr_pkg::iedr_mem_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (we) begin
      s_nxt.cells[addr] = wdata;
    end
  end

  // Cleared at reset so reads before any write are defined
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.cells[addr];

endmodule // iedr_mem

// ---- iedr_regs.sv ----
// Interrupt masks, tone digit status and indirect access registers
// Function
// - Alarm mask bits 7:2 gate six alarms
// - Mask bit 1 gates loop closure
// - Mask bit 0 gates ring trip
// - Misc bit 2 gates calibration error
// - Misc bit 1 gates indirect done
// - Misc bit 0 gates tone detected
// - Digit status bit 4 shows valid
// - Low nibble carries the digit code
// - Indirect data split into two bytes
// - Data then address write stores on tick
// - Address-only write loads data on tick
// - Status bit 0 shows access pending
// - Serviced access sets done pending flag
// - Hook change during calibration flags error
// - Writing one clears a pending flag
`timescale 1ns/10ps
`include "iedr_map.svh"
module iedr_regs #(
  parameter int TICK_CYCLES = `IEDR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  // Register port from the serial control decoder
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // Line events, one-cycle pulses on this clock
  input  wire logic [5:0] ALARM_EVT,
  input  wire logic       LOOP_EVT,
  input  wire logic       RTRIP_EVT,
  // Calibration and hook state
  input  wire logic       CAL_ACTIVE,
  input  wire logic       HOOK_PIN,
  // Tone detector
  input  wire logic       DIGIT_VALID,
  input  wire logic [3:0] DIGIT_CODE,
  // Interrupt request
  output logic            IRQ_N
);

  iedr_pkg::iedr_state_s s_r;
  iedr_pkg::iedr_state_s s_nxt;
  iedr_pkg::iedr_evt_s   evt;

  logic        tick;
  logic        mem_we;
  logic [15:0] mem_rdata;
  logic        ind_service;

  // Decoded write strobes, one per writable offset
  logic        wr_alarm_pend;
  logic        wr_misc_pend;
  logic        wr_alarm_mask;
  logic        wr_misc_mask;
  logic        wr_data_lo;
  logic        wr_data_hi;
  logic        wr_addr;

  // Mask fields under their own names
  logic        alarm6_irq_en;
  logic        alarm5_irq_en;
  logic        alarm4_irq_en;
  logic        alarm3_irq_en;
  logic        alarm2_irq_en;
  logic        alarm1_irq_en;
  logic        loop_closure_irq_en;
  logic        ring_trip_irq_en;
  logic        cm_cal_err_irq_en;
  logic        indirect_done_irq_en;
  logic        tone_digit_irq_en;

  // Pending and status fields under their own names
  logic        cm_cal_err_pending;
  logic        indirect_done_pending;
  logic        tone_digit_pending;
  logic        indirect_pending;
  logic        digit_valid;
  logic [3:0]  digit_code;

  // Enables, flags and gated requests as vectors
  logic [7:0]  alarm_en;
  logic [2:0]  misc_en;
  logic [2:0]  misc_flags;
  logic [7:0]  alarm_req;
  logic [2:0]  misc_req;
  logic        any_req;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `IEDR_OFS_ALARM_PEND) || (a == `IEDR_OFS_MISC_PEND) ||
                (a == `IEDR_OFS_ALARM_MASK) || (a == `IEDR_OFS_MISC_MASK) ||
                (a == `IEDR_OFS_DIGIT_STAT) || (a == `IEDR_OFS_IDATA_LO) ||
                (a == `IEDR_OFS_IDATA_HI) || (a == `IEDR_OFS_IADDR) ||
                (a == `IEDR_OFS_ISTAT);
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = wr && (a == ofs);
  endfunction

  iedr_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (CLK),
    .reset_n (RESET_N),
    .tick    (tick)
  );

  // Indirect store commit
  assign mem_we = ind_service && (s_r.iop == iedr_pkg::IEDR_OP_WRITE);

  iedr_mem u_mem (
    .clk     (CLK),
    .reset_n (RESET_N),
    .we      (mem_we),
    .addr    (s_r.iaddr),
    .wdata   (s_r.idata),
    .rdata   (mem_rdata)
  );

  assign evt = '{alarm: ALARM_EVT, loop_closure: LOOP_EVT,
                 ring_trip: RTRIP_EVT};

  // A pending access is serviced by the tick that finds it
  assign ind_service = tick && s_r.ipend;

  assign wr_alarm_pend = wr_hit(REG_WR, REG_ADDR, `IEDR_OFS_ALARM_PEND);
  assign wr_misc_pend  = wr_hit(REG_WR, REG_ADDR, `IEDR_OFS_MISC_PEND);
  assign wr_alarm_mask = wr_hit(REG_WR, REG_ADDR, `IEDR_OFS_ALARM_MASK);
  assign wr_misc_mask  = wr_hit(REG_WR, REG_ADDR, `IEDR_OFS_MISC_MASK);
  assign wr_data_lo    = wr_hit(REG_WR, REG_ADDR, `IEDR_OFS_IDATA_LO);
  assign wr_data_hi    = wr_hit(REG_WR, REG_ADDR, `IEDR_OFS_IDATA_HI);
  assign wr_addr       = wr_hit(REG_WR, REG_ADDR, `IEDR_OFS_IADDR);

  assign alarm6_irq_en = s_r.alarm_mask[`IEDR_ALARM_HI_BIT];
  assign alarm5_irq_en = s_r.alarm_mask[6];
  assign alarm4_irq_en = s_r.alarm_mask[5];
  assign alarm3_irq_en = s_r.alarm_mask[4];
  assign alarm2_irq_en = s_r.alarm_mask[3];
  assign alarm1_irq_en = s_r.alarm_mask[`IEDR_ALARM_LO_BIT];
  assign loop_closure_irq_en = s_r.alarm_mask[`IEDR_LOOP_BIT];
  assign ring_trip_irq_en = s_r.alarm_mask[`IEDR_RTRIP_BIT];
  assign cm_cal_err_irq_en = s_r.misc_mask[`IEDR_CMCAL_BIT];
  assign indirect_done_irq_en = s_r.misc_mask[`IEDR_INDDONE_BIT];
  assign tone_digit_irq_en = s_r.misc_mask[`IEDR_TONE_BIT];

  assign cm_cal_err_pending    = s_r.misc_pend[`IEDR_CMCAL_BIT];
  assign indirect_done_pending = s_r.misc_pend[`IEDR_INDDONE_BIT];
  assign tone_digit_pending    = s_r.misc_pend[`IEDR_TONE_BIT];
  assign indirect_pending      = s_r.ipend;
  assign digit_valid           = s_r.digit_valid;
  assign digit_code            = s_r.digit_code;

  assign alarm_en = {alarm6_irq_en, alarm5_irq_en, alarm4_irq_en,
                     alarm3_irq_en, alarm2_irq_en, alarm1_irq_en,
                     loop_closure_irq_en, ring_trip_irq_en};
  assign misc_en = {cm_cal_err_irq_en, indirect_done_irq_en,
                    tone_digit_irq_en};
  assign misc_flags = {cm_cal_err_pending, indirect_done_pending,
                       tone_digit_pending};

  // One gate per source; masked flags stay recorded
  for (genvar g = 0; g < 8; g++) begin : g_alarm_gate
    assign alarm_req[g] = s_r.alarm_pend[g] & alarm_en[g];
  end
  for (genvar g = 0; g < 3; g++) begin : g_misc_gate
    assign misc_req[g] = misc_flags[g] & misc_en[g];
  end
  assign any_req = |{alarm_req, misc_req};

  always_comb begin
    logic       hook_agree;
    logic       hook_change;
    logic [7:0] alarm_set;
    logic [7:0] alarm_clr;
    logic [2:0] misc_set;
    logic [2:0] misc_clr;
    logic [7:0] rd;
    hook_agree  = 1'b0;
    hook_change = 1'b0;
    alarm_set   = 8'h00;
    alarm_clr   = 8'h00;
    misc_set    = 3'h0;
    misc_clr    = 3'h0;
    rd          = `IEDR_RST_BYTE;
    s_nxt = s_r;

    // Hook pin: only stage two and three are compared
    s_nxt.hook_sync = {s_r.hook_sync[1:0], HOOK_PIN};
    hook_agree = (s_r.hook_sync[1] == s_r.hook_sync[2]);
    if (hook_agree) begin
      hook_change = s_r.hook_seen && (s_r.hook_sync[2] != s_r.hook_prev);
      s_nxt.hook_prev = s_r.hook_sync[2];
      s_nxt.hook_seen = 1'b1;
    end

    s_nxt.digit_valid = DIGIT_VALID;
    s_nxt.digit_code = iedr_pkg::iedr_digit_e'(DIGIT_CODE);
    s_nxt.valid_prev = DIGIT_VALID;

    // Event sources
    alarm_set = evt;
    misc_set[`IEDR_CMCAL_BIT] = hook_change && CAL_ACTIVE;
    misc_set[`IEDR_INDDONE_BIT] = ind_service;
    misc_set[`IEDR_TONE_BIT] = DIGIT_VALID && !s_r.valid_prev;

    if (wr_alarm_pend) begin
      alarm_clr = REG_WDATA;
    end
    if (wr_misc_pend) begin
      misc_clr = REG_WDATA[2:0];
    end
    s_nxt.alarm_pend = (s_r.alarm_pend & ~alarm_clr) | alarm_set;
    s_nxt.misc_pend  = (s_r.misc_pend & ~misc_clr) | misc_set;

    if (ind_service) begin
      s_nxt.ipend = 1'b0;
      if (s_r.iop == iedr_pkg::IEDR_OP_READ) begin
        s_nxt.idata = mem_rdata;
      end
    end

    // Host writes after the tick so a new request is never dropped
    // Alarm mask write
    if (wr_alarm_mask) begin
      s_nxt.alarm_mask = REG_WDATA;
    end
    // Misc mask write, upper bits dropped
    if (wr_misc_mask) begin
      s_nxt.misc_mask = REG_WDATA[2:0];
    end
    if (wr_data_lo) begin
      s_nxt.idata[7:0] = REG_WDATA;
      s_nxt.data_dirty = 1'b1;
    end
    if (wr_data_hi) begin
      s_nxt.idata[15:8] = REG_WDATA;
      s_nxt.data_dirty = 1'b1;
    end
    if (wr_addr) begin
      s_nxt.iaddr = REG_WDATA;
      s_nxt.ipend = 1'b1;
      // Op is judged on the data flag before it is cleared below
      s_nxt.iop = s_r.data_dirty ? iedr_pkg::IEDR_OP_WRITE
                                 : iedr_pkg::IEDR_OP_READ;
      s_nxt.data_dirty = 1'b0;
    end

    // Read mux; reserved bits and unmapped offsets read zero
    if (is_mapped(REG_ADDR)) begin
      unique case (REG_ADDR)
        `IEDR_OFS_ALARM_PEND: rd = s_r.alarm_pend;
        `IEDR_OFS_MISC_PEND:  rd = {5'h00, s_r.misc_pend};
        `IEDR_OFS_ALARM_MASK: rd = s_r.alarm_mask;
        `IEDR_OFS_MISC_MASK:  rd = {5'h00, s_r.misc_mask};
        `IEDR_OFS_DIGIT_STAT: rd = {3'h0, digit_valid, digit_code};
        `IEDR_OFS_IDATA_LO:   rd = s_r.idata[7:0];
        `IEDR_OFS_IDATA_HI:   rd = s_r.idata[15:8];
        `IEDR_OFS_IADDR:      rd = s_r.iaddr;
        `IEDR_OFS_ISTAT:      rd = {7'h00, indirect_pending};
        default:              rd = `IEDR_RST_BYTE;
      endcase
    end
    if (REG_RD) begin
      s_nxt.rdata = rd;
    end

    s_nxt.irq_n = ~any_req;
  end

  // Data and address cleared at reset
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      s_r       <= '0;
      s_r.irq_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA = s_r.rdata;
  assign IRQ_N     = s_r.irq_n;

endmodule // iedr_regs

// ---- iedr_regs_sva.sv ----
// Port-level checks for the mask, tone status and indirect access block
`timescale 1ns/10ps
module iedr_regs_sva (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RESET_N,
  // Register port
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  // Events, tone and interrupt
  input wire logic       LOOP_EVT,
  input wire logic       DIGIT_VALID,
  input wire logic [3:0] DIGIT_CODE,
  input wire logic       IRQ_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_rd(a);
    REG_RD && REG_ADDR == a;
  endsequence
  sequence s_wr(a);
    REG_WR && REG_ADDR == a;
  endsequence
  sequence s_loop_on;
    (REG_WR && REG_ADDR == 8'h16 && REG_WDATA[1]) ##1 (LOOP_EVT && !REG_WR);
  endsequence

  chk_rdata_hold:
    assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  chk_istat_rsv:
    assert property (s_rd(8'h1F) |=> REG_RDATA[7:1] == 7'h00)
    else $error("access status upper bits not zero");
  chk_digit_read:
    assert property (s_rd(8'h18) |=> REG_RDATA ==
      {3'h0, $past(DIGIT_VALID, 2), $past(DIGIT_CODE, 2)})
    else $error("digit status differs from detector");
  chk_misc_rsv:
    assert property (s_rd(8'h17) |=> REG_RDATA[7:3] == 5'h00)
    else $error("misc mask reserved bits not zero");
  chk_pend_rsv:
    assert property (s_rd(8'h14) |=> REG_RDATA[7:3] == 5'h00)
    else $error("misc pending reserved bits not zero");
  chk_irq_release:
    assert property ($rose(IRQ_N) |-> $past(REG_WR, 2))
    else $error("interrupt released without a write");
  chk_data_low:
    assert property (s_wr(8'h1C) ##2 s_rd(8'h1C)
      |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("data low read differs from write");
  chk_loop_irq:
    assert property (s_loop_on |-> ##2 !IRQ_N)
    else $error("enabled loop event gave no interrupt");
endmodule // iedr_regs_sva

// ---- iedr_regs_bench.sv ----
// Self-checking bench for the mask, tone status and indirect block
`timescale 1ns/10ps
module iedr_regs_bench;
  // Short tick keeps indirect waits brief
  localparam int TICK = 16;
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [7:0]  REG_WDATA = 8'h00;
  logic [7:0]  REG_RDATA;
  logic [5:0]  ALARM_EVT = 6'h00;
  logic        LOOP_EVT = 1'b0;
  logic        RTRIP_EVT = 1'b0;
  logic        CAL_ACTIVE = 1'b0;
  logic        HOOK_PIN = 1'b0;
  logic        DIGIT_VALID = 1'b0;
  logic [3:0]  DIGIT_CODE = 4'h0;
  logic        IRQ_N;
  int          err_count = 0;
  int          num_checks = 0;
  logic [7:0]  d;
  // Rows: write flag, offset, write data, expected read
  logic [24:0] rows [13] = '{
    {1'b0, 8'h1C, 8'h00, 8'h00}, {1'b0, 8'h1F, 8'h00, 8'h00},
    {1'b1, 8'h16, 8'hA5, 8'h00}, {1'b0, 8'h16, 8'h00, 8'hA5},
    {1'b1, 8'h17, 8'hFF, 8'h00}, {1'b0, 8'h17, 8'h00, 8'h07},
    {1'b1, 8'h1D, 8'hC3, 8'h00}, {1'b1, 8'h1C, 8'h3C, 8'h00},
    {1'b0, 8'h1C, 8'h00, 8'h3C}, {1'b0, 8'h1D, 8'h00, 8'hC3},
    {1'b1, 8'h18, 8'hFF, 8'h00}, {1'b0, 8'h18, 8'h00, 8'h00},
    {1'b0, 8'h20, 8'h00, 8'h00}};

  iedr_regs #(.TICK_CYCLES(TICK)) i_iedr_regs (
    .CLK(CLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .ALARM_EVT(ALARM_EVT), .LOOP_EVT(LOOP_EVT), .RTRIP_EVT(RTRIP_EVT),
    .CAL_ACTIVE(CAL_ACTIVE), .HOOK_PIN(HOOK_PIN),
    .DIGIT_VALID(DIGIT_VALID), .DIGIT_CODE(DIGIT_CODE), .IRQ_N(IRQ_N));

  initial begin
    forever #2 CLK = ~CLK;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, v);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
    v = REG_RDATA;
  endtask

  task automatic pulse(input logic [7:0] v);
    {ALARM_EVT, LOOP_EVT, RTRIP_EVT} <= v;
    @(posedge CLK);
    {ALARM_EVT, LOOP_EVT, RTRIP_EVT} <= 8'h00;
  endtask

  task automatic irq(input logic e);
    repeat (2) @(posedge CLK);
    chk("interrupt", {7'h00, IRQ_N}, {7'h00, e});
  endtask

  // Poll is bounded: a stuck request ends the run
  // Wait for idle
  task automatic wait_idle();
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      rd(8'h1F, s);
      n++;
    end while (s[0] !== 1'b0 && n < 20);
    if (s[0] !== 1'b0) begin
      chk("pending wait", s, 8'h00);
      stop_test();
    end
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, e);
    logic [7:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      else begin
        rd(rows[i][23:16], d);
        chk("table read", d, rows[i][7:0]);
      end
    end
    wr(8'h1C, 8'h34);
    wr(8'h1D, 8'h12);
    wr(8'h1E, 8'h05);
    wait_idle();
    rdchk("misc pending", 8'h14, 8'h02);
    // Issued midway between two ticks, so it is still pending when read
    wr(8'h1E, 8'h06);
    rdchk("access pending", 8'h1F, 8'h01);
    wait_idle();
    rdchk("read op low", 8'h1C, 8'h00);
    wr(8'h1E, 8'h05);
    wait_idle();
    rdchk("stored low", 8'h1C, 8'h34);
    rdchk("stored high", 8'h1D, 8'h12);
    wr(8'h17, 8'h00);
    irq(1'b1);
    wr(8'h17, 8'h02);
    irq(1'b0);
    wr(8'h14, 8'h02);
    irq(1'b1);
    rdchk("cleared", 8'h14, 8'h00);
    wr(8'h16, 8'h00);
    pulse(8'hFF);
    irq(1'b1);
    rdchk("masked pending", 8'h13, 8'hFF);
    wr(8'h13, 8'hFF);
    rdchk("alarm clear", 8'h13, 8'h00);
    for (int b = 0; b < 8; b++) begin
      wr(8'h16, 8'h01 << b);
      pulse(8'h01 << b);
      irq(1'b0);
      wr(8'h13, 8'hFF);
      irq(1'b1);
    end
    CAL_ACTIVE <= 1'b1;
    HOOK_PIN <= 1'b1;
    repeat (8) @(posedge CLK);
    CAL_ACTIVE <= 1'b0;
    rdchk("cal error", 8'h14, 8'h04);
    wr(8'h17, 8'h04);
    irq(1'b0);
    wr(8'h14, 8'h04);
    irq(1'b1);
    for (int c = 0; c < 16; c++) begin
      DIGIT_CODE <= 4'(c);
      DIGIT_VALID <= 1'b1;
      rdchk("digit", 8'h18, {4'h1, 4'(c)});
    end
    DIGIT_VALID <= 1'b0;
    rdchk("digit idle", 8'h18, 8'h0F);
    rdchk("tone pending", 8'h14, 8'h01);
    wr(8'h17, 8'h01);
    irq(1'b0);
    wr(8'h14, 8'h01);
    irq(1'b1);
    stop_test();
  end
endmodule // iedr_regs_bench

bind iedr_regs iedr_regs_sva i_iedr_regs_sva (
  .CLK(CLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .LOOP_EVT(LOOP_EVT), .DIGIT_VALID(DIGIT_VALID),
  .DIGIT_CODE(DIGIT_CODE), .IRQ_N(IRQ_N));
